// ===== logic/cbc_pkg.sv
// Shared constants and carrier types for the backplane bus cycle logic.
package cbc_pkg;

   // Clock and clock-state timing.
   localparam int unsigned CLK_MHZ   = 125;
   localparam int unsigned STATE_NS  = 500;
   localparam int unsigned STATE_CYC = (STATE_NS * CLK_MHZ) / 1000;
   localparam logic [5:0]  CNT_ZERO   = 6'h00;
   localparam logic [5:0]  CNT_ONE    = 6'h01;
   localparam logic [5:0]  STATE_LAST = 6'(STATE_CYC - 1);
   localparam logic [5:0]  PHI2_POS   = 6'(STATE_CYC / 2);

   // Opcodes that start the two supported cycles.
   localparam logic [7:0]  OP_INPUT = 8'hDB;
   localparam logic [7:0]  OP_STORE = 8'h32;

   // Machine cycle numbers of the supported cycles within their instruction.
   localparam logic [2:0]  MCYC_NONE   = 3'h0;
   localparam logic [2:0]  MCYC_INPUT  = 3'h3;
   localparam logic [2:0]  MCYC_MEMORY_WRITE_STROBE = 3'h4;

   // Status byte layout and values.
   localparam int unsigned ST_WO_N_BIT  = 1;
   localparam int unsigned ST_OUT_BIT   = 4;
   localparam int unsigned ST_INP_BIT   = 6;
   localparam logic [7:0]  STATUS_RESET  = 8'h02;
   localparam logic [7:0]  STATUS_INPUT  = 8'h42;
   localparam logic [7:0]  STATUS_MEMORY_WRITE_STROBE = 8'h00;

   // Reset values of the data paths.
   localparam logic [15:0] ADDR_RESET = 16'h0000;
   localparam logic [15:0] PC_RESET   = 16'h0000;
   localparam logic [15:0] PC_STEP    = 16'h0001;
   localparam logic [7:0]  BYTE_RESET = 8'h00;

   typedef enum logic [1:0] {ST_IDLE, ST_T1, ST_T2, ST_T3} cbc_fsm_type;
   typedef enum logic {KIND_INPUT, KIND_MEMORY_WRITE_STROBE} cbc_kind_type;

   typedef struct packed {
      logic        valid;
      logic [7:0]  opcode;
      logic [15:0] address;
      logic [7:0]  data;
   } cbc_cmd_type;

   typedef struct packed {
      logic [15:0] address_lines;
      logic [7:0]  data_out_lines;
      logic        data_out_oe;
      logic        bus_cycle_sync;
      logic        status_strobe_n;
      logic        input_cycle_status;
      logic        output_cycle_status;
      logic        write_output_status_n;
      logic        bus_read_strobe;
      logic        bus_write_strobe_n;
      logic        memory_write_strobe;
   } cbc_bus_type;

   typedef struct packed {
      logic chip_select_n;
      logic buffer_in_enable_n;
      logic cpu_data_in_enable;
      logic data_gate;
   } cbc_buf_type;

   typedef struct packed {
      logic [15:0] address;
      logic        input_indicator;
      logic        write_out_indicator;
   } cbc_panel_type;

   typedef struct packed {
      cbc_fsm_type   fsm;
      cbc_kind_type  kind;
      logic [15:0]   addr;
      logic [7:0]    wdata;
      logic [7:0]    pend_status;
      logic [7:0]    status;
      logic [7:0]    rdata;
      logic [15:0]   pc;
      logic [2:0]    mcycle;
      logic          ready;
      logic          cmd_taken;
      logic          done;
      cbc_bus_type   bus;
      cbc_buf_type   bufc;
      cbc_panel_type panel;
   } cbc_state_type;

endpackage

// ===== logic/cbc_phase_gen.sv
// Two-phase clock-state divider producing one enable pulse per phase.
`timescale 1ns/1ps
`default_nettype none
module cbc_phase_gen
   import cbc_pkg::*;
(
   // Clock and reset.
   input  wire logic i_mclk,
   input  wire logic i_rst_n,
   // Phase pulses.
   output var  logic o_phi1,
   output var  logic o_phi2
);

   typedef struct packed {
      logic [5:0] cnt;
      logic       phi1;
      logic       phi2;
   } cbc_pg_state_type;

   cbc_pg_state_type q;
   cbc_pg_state_type d;

   always_comb begin
      d      = q;
      d.cnt  = (q.cnt == STATE_LAST) ? CNT_ZERO : q.cnt + CNT_ONE;
      d.phi1 = (d.cnt == CNT_ZERO);
      d.phi2 = (d.cnt == PHI2_POS);
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         q <= '{cnt: CNT_ZERO, phi1: 1'b0, phi2: 1'b0};
      end else begin
         q <= d;
      end
   end

   assign o_phi1 = q.phi1;
   assign o_phi2 = q.phi2;

endmodule
`default_nettype wire

// ===== logic/cbc_bus_cycles.sv
// Input read and memory write machine cycles of the processor card.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Program counter holds from operand read until the input read cycle completes.
// - Input read drives the device number on both address bytes.
// - Input read cycle spans two and a half clock states, ending at the third state's phase-two pulse.
// - Late first state: address and cycle sync driven; the status byte follows at second state start.
// - Status passes the buffers while chip select and in-enable are low.
// - Status strobe low at second state start latches the status byte.
// - Latched input-cycle status goes high for an input read.
// - Read strobe raised late second state; the card returns data in.
// - Inbound gate opens only with read strobe and panel gate both high.
// - Program counter increments in the same cycle as the input byte is stored.
// - Store-accumulator runs a memory write as its fourth machine cycle.
// - Memory write cycle spans three clock states of two phases each.
// - Write status: output-cycle status low for memory writes.
// - Write-output status driven low and shown inverted on the panel.
// - Third write state starts with the data byte on data out lines.
// - Write strobe goes low only after the write data has settled.
// - Memory write strobe high when write strobe low and output status low.
// - Input status and address are forwarded to the front panel.
// - Output-cycle status suppresses the memory write strobe.
module cbc_bus_cycles
   import cbc_pkg::*;
(
   // Clock and reset.
   input  wire logic          i_mclk,
   input  wire logic          i_rst_n,
   // Cycle request from the instruction sequencer.
   input  wire cbc_cmd_type   i_cmd,
   output var  logic          o_ready,
   output var  logic          o_cmd_taken,
   // Backplane pins.
   input  wire logic [7:0]    i_data_in_lines,
   input  wire logic          i_panel_data_gate,
   output var  cbc_bus_type   o_bus,
   // Bidirectional buffer control.
   output var  cbc_buf_type   o_buf,
   // Front panel display.
   output var  cbc_panel_type o_panel,
   // Processor side results.
   output var  logic [7:0]    o_read_data,
   output var  logic          o_done,
   output var  logic [15:0]   o_pc,
   output var  logic [2:0]    o_mcycle
);

   localparam cbc_state_type STATE_RESET = '{
      fsm:         ST_IDLE,
      kind:        KIND_INPUT,
      addr:        ADDR_RESET,
      wdata:       BYTE_RESET,
      pend_status: STATUS_RESET,
      status:      STATUS_RESET,
      rdata:       BYTE_RESET,
      pc:          PC_RESET,
      mcycle:      MCYC_NONE,
      ready:       1'b1,
      cmd_taken:   1'b0,
      done:        1'b0,
      bus:         '{address_lines: ADDR_RESET, data_out_lines: BYTE_RESET,
                     data_out_oe: 1'b0, bus_cycle_sync: 1'b0, status_strobe_n: 1'b1,
                     input_cycle_status: 1'b0, output_cycle_status: 1'b0,
                     write_output_status_n: 1'b1, bus_read_strobe: 1'b0,
                     bus_write_strobe_n: 1'b1, memory_write_strobe: 1'b0},
      bufc:        '{chip_select_n: 1'b1, buffer_in_enable_n: 1'b0,
                     cpu_data_in_enable: 1'b0, data_gate: 1'b0},
      panel:       '{address: ADDR_RESET, input_indicator: 1'b0,
                     write_out_indicator: 1'b0}
   };

   cbc_state_type q;
   cbc_state_type d;
   logic          phi1;
   logic          phi2;
   logic [8:0]    pins_s;
   logic [7:0]    din_s;
   logic          gate_s;

   cbc_phase_gen u_phase (
      .i_mclk  (i_mclk),
      .i_rst_n (i_rst_n),
      .o_phi1  (phi1),
      .o_phi2  (phi2)
   );

   // The panel gate and data lines arrive from other cards without a common clock.
   cbc_sync3 #(.W(9)) u_sync (
      .i_mclk  (i_mclk),
      .i_rst_n (i_rst_n),
      .i_async ({i_panel_data_gate, i_data_in_lines}),
      .o_sync  (pins_s)
   );

   assign din_s  = pins_s[7:0];
   assign gate_s = pins_s[8];

   always_comb begin
      d           = q;
      d.cmd_taken = 1'b0;
      d.done      = 1'b0;
      case (q.fsm)
         ST_IDLE: begin
            // Cycles start on a phase-one pulse so each state is a full phase pair.
            if (phi1 && i_cmd.valid) begin
               d.cmd_taken = 1'b1;
               if (i_cmd.opcode == OP_INPUT) begin
                  d.kind          = KIND_INPUT;
                  d.addr          = {i_cmd.address[7:0], i_cmd.address[7:0]};
                  d.pend_status   = STATUS_INPUT;
                  d.mcycle        = MCYC_INPUT;
                  d.fsm           = ST_T1;
                  d.bufc.chip_select_n = 1'b0;
               end else if (i_cmd.opcode == OP_STORE) begin
                  d.kind          = KIND_MEMORY_WRITE_STROBE;
                  d.addr          = i_cmd.address;
                  d.wdata         = i_cmd.data;
                  d.pend_status   = STATUS_MEMORY_WRITE_STROBE;
                  d.mcycle        = MCYC_MEMORY_WRITE_STROBE;
                  d.fsm           = ST_T1;
                  d.bufc.chip_select_n = 1'b0;
               end
            end
         end
         ST_T1: begin
            if (phi2) begin
               d.bus.address_lines      = q.addr;
               d.bus.bus_cycle_sync     = 1'b1;
               d.panel.address          = q.addr;
               d.bufc.buffer_in_enable_n = 1'b0;
            end else if (phi1) begin
               d.fsm                   = ST_T2;
               d.bus.status_strobe_n   = 1'b0;
               d.status                = q.pend_status;
               d.bus.input_cycle_status    = d.status[ST_INP_BIT];
               d.bus.output_cycle_status   = d.status[ST_OUT_BIT];
               d.bus.write_output_status_n = d.status[ST_WO_N_BIT];
               d.panel.input_indicator     = d.status[ST_INP_BIT];
               d.panel.write_out_indicator = ~d.status[ST_WO_N_BIT];
            end
         end
         ST_T2: begin
            if (phi2) begin
               d.bus.status_strobe_n = 1'b1;
               d.bus.bus_cycle_sync  = 1'b0;
               if (q.kind == KIND_INPUT) begin
                  d.bufc.cpu_data_in_enable = 1'b1;
                  d.bus.bus_read_strobe     = 1'b1;
                  d.bufc.buffer_in_enable_n = 1'b1;
               end
            end else if (phi1) begin
               d.fsm = ST_T3;
               if (q.kind == KIND_MEMORY_WRITE_STROBE) begin
                  d.bus.data_out_lines = q.wdata;
                  d.bus.data_out_oe    = 1'b1;
               end
            end
         end
         ST_T3: begin
            if (phi2) begin
               if (q.kind == KIND_INPUT) begin
                  // A closed panel gate leaves the old byte; the cycle still ends.
                  if (q.bufc.data_gate) begin
                     d.rdata = din_s;
                  end
                  d.bufc.cpu_data_in_enable = 1'b0;
                  d.bus.bus_read_strobe     = 1'b0;
                  d.bufc.buffer_in_enable_n = 1'b0;
                  d.bufc.chip_select_n      = 1'b1;
                  d.pc                      = q.pc + PC_STEP;
                  d.done                    = 1'b1;
                  d.fsm                     = ST_IDLE;
               end else begin
                  // Half a state after the data went out, so it has settled.
                  d.bus.bus_write_strobe_n = 1'b0;
               end
            end else if (phi1 && !q.bus.bus_write_strobe_n) begin
               d.bus.bus_write_strobe_n = 1'b1;
               d.bus.data_out_oe        = 1'b0;
               d.bufc.chip_select_n     = 1'b1;
               d.done                   = 1'b1;
               d.fsm                    = ST_IDLE;
            end
         end
         default: begin
            d.fsm = ST_IDLE;
         end
      endcase
      // The program counter is untouched anywhere else during a cycle.
      d.bufc.data_gate = d.bus.bus_read_strobe & gate_s;
      d.bus.memory_write_strobe = ~d.bus.bus_write_strobe_n
                                & ~d.bus.output_cycle_status;
      d.ready = (d.fsm == ST_IDLE);
      // Status fields change only at a strobe, so they stay valid afterwards.
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         q <= STATE_RESET;
      end else begin
         q <= d;
      end
   end

   assign o_ready     = q.ready;
   assign o_cmd_taken = q.cmd_taken;
   assign o_bus       = q.bus;
   assign o_buf       = q.bufc;
   assign o_panel     = q.panel;
   assign o_read_data = q.rdata;
   assign o_done      = q.done;
   assign o_pc        = q.pc;
   assign o_mcycle    = q.mcycle;

endmodule
`default_nettype wire

// ===== logic/cbc_sync3.sv
// Three-stage input synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module cbc_sync3 #(
   parameter int unsigned W = 1
) (
   // Clock and reset.
   input  wire logic         i_mclk,
   input  wire logic         i_rst_n,
   // Asynchronous input and its settled copy.
   input  wire logic [W-1:0] i_async,
   output var  logic [W-1:0] o_sync
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] val;
   } cbc_sy_state_type;

   cbc_sy_state_type q;
   cbc_sy_state_type d;

   always_comb begin
      d    = q;
      d.s1 = i_async;
      d.s2 = q.s1;
      d.s3 = q.s2;
      // Stage one is never compared; only the two later stages vote.
      if (q.s2 == q.s3) begin
         d.val = q.s3;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign o_sync = q.val;

endmodule
`default_nettype wire

// ===== tb/cbc_checker.sv
// Concurrent checks on the bus cycle ports.
`timescale 1ns/1ps
`default_nettype none
module cbc_checker
   import cbc_pkg::*;
(
   // Watched ports.
   input  wire logic          i_mclk,
   input  wire logic          i_rst_n,
   input  wire logic          o_ready,
   input  wire logic          o_done,
   input  wire logic [15:0]   o_pc,
   input  wire cbc_bus_type   o_bus,
   input  wire cbc_buf_type   o_buf,
   input  wire cbc_panel_type o_panel
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   pc_hold_a: assert property (!o_ready |-> $stable(o_pc))
      else $error("pc moved in a cycle");
   dev_dup_a: assert property (o_bus.bus_read_strobe |->
      o_bus.address_lines[15:8] == o_bus.address_lines[7:0]) else $error("device byte");
   sync_strobe_a: assert property ($rose(o_bus.bus_cycle_sync) |->
      ##31 !o_bus.status_strobe_n) else $error("strobe late");
   buf_open_a: assert property (o_bus.bus_cycle_sync |->
      !o_buf.chip_select_n && !o_buf.buffer_in_enable_n) else $error("buffers closed");
   strobe_len_a: assert property ($fell(o_bus.status_strobe_n) |->
      ##31 o_bus.status_strobe_n && !o_bus.bus_cycle_sync) else $error("strobe length");
   inp_len_a: assert property ($fell(o_bus.status_strobe_n) &&
      o_bus.input_cycle_status |-> ##93 o_done && !o_bus.bus_read_strobe)
      else $error("input length");
   rd_strobe_a: assert property ($fell(o_bus.status_strobe_n) &&
      o_bus.input_cycle_status |-> ##31 o_bus.bus_read_strobe && o_buf.cpu_data_in_enable)
      else $error("read strobe");
   wr_len_a: assert property ($fell(o_bus.status_strobe_n) &&
      !o_bus.write_output_status_n |-> ##124 o_done && o_bus.bus_write_strobe_n)
      else $error("write length");
   wr_data_a: assert property ($fell(o_bus.bus_write_strobe_n) |->
      o_bus.data_out_oe && $past(o_bus.data_out_oe, 20)) else $error("data not settled");
   mwr_rel_a: assert property (o_bus.memory_write_strobe ==
      (!o_bus.bus_write_strobe_n && !o_bus.output_cycle_status)) else $error("mem strobe");
   wr_status_a: assert property (!o_bus.write_output_status_n |->
      !o_bus.output_cycle_status) else $error("output status set");
   st_hold_a: assert property (o_bus.status_strobe_n &&
      $past(o_bus.status_strobe_n) |->
      $stable({o_bus.input_cycle_status, o_bus.write_output_status_n})) else $error("latch");
   panel_a: assert property (o_panel.address == o_bus.address_lines &&
      o_panel.input_indicator == o_bus.input_cycle_status &&
      o_panel.write_out_indicator == !o_bus.write_output_status_n) else $error("panel");
   gate_a: assert property (o_buf.data_gate |-> o_bus.bus_read_strobe ||
      $past(o_bus.bus_read_strobe)) else $error("gate open");
   rd_done_a: assert property ($fell(o_bus.bus_read_strobe) |->
      o_done && o_pc == $past(o_pc) + 16'h0001) else $error("pc step");
endmodule
bind cbc_bus_cycles cbc_checker i_chk (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .o_ready(o_ready),
   .o_done(o_done), .o_pc(o_pc), .o_bus(o_bus), .o_buf(o_buf), .o_panel(o_panel));
`default_nettype wire

// ===== tb/cbc_card_model.sv
// Behavioural memory card and I/O card on the far side of the backplane.
`timescale 1ns/1ps
`default_nettype none
module cbc_card_model
   import cbc_pkg::*;
(
   // Clock and backplane from the processor card.
   input  wire logic        i_mclk,
   input  wire cbc_bus_type i_bus,
   // Returned data and memory write log.
   output var  logic [7:0]  o_data_in,
   output var  logic [15:0] o_wr_addr,
   output var  logic [7:0]  o_wr_data,
   output var  int          o_wr_count
);
   logic [15:0] dec_addr;
   logic        mwr_q;
   initial begin
      o_data_in = 8'h00;
      o_wr_count = 0;
      mwr_q = 1'b0;
   end
   always @(posedge i_mclk) begin
      if (i_bus.bus_cycle_sync) begin
         dec_addr <= i_bus.address_lines;
      end
      // Released lines toggle each cycle, so a badly timed sample cannot match by chance.
      if (i_bus.bus_read_strobe && i_bus.input_cycle_status) begin
         o_data_in <= i_bus.address_lines[7:0] ^ 8'h5A;
      end else begin
         o_data_in <= ~o_data_in;
      end
      mwr_q <= i_bus.memory_write_strobe;
      if (i_bus.memory_write_strobe && !mwr_q) begin
         o_wr_addr <= dec_addr;
         o_wr_data <= i_bus.data_out_oe ? i_bus.data_out_lines : ~i_bus.data_out_lines;
         o_wr_count <= o_wr_count + 1;
      end
   end
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the input read and memory write cycles.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_mismatch++; \
   $display("Error at %0t: got %h want %h", $time, (a), (b)); end end
module testbench
   import cbc_pkg::*;
;
   logic          i_mclk = 1'b0;
   logic          i_rst_n = 1'b0;
   cbc_cmd_type   cmd;
   logic          gate;
   logic [7:0]    din, rdata, exp_rd, wr_data;
   logic          ready, taken, done;
   cbc_bus_type   bus;
   cbc_buf_type   bufc;
   cbc_panel_type panel;
   logic [15:0]   pc, wr_addr;
   logic [2:0]    mcycle;
   int            n_mismatch = 0, total_checks = 0, cyc = 0, wr_count;
   always #4 i_mclk = ~i_mclk;
   cbc_bus_cycles i_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_cmd(cmd), .o_ready(ready),
      .o_cmd_taken(taken), .i_data_in_lines(din), .i_panel_data_gate(gate), .o_bus(bus),
      .o_buf(bufc), .o_panel(panel), .o_read_data(rdata), .o_done(done), .o_pc(pc),
      .o_mcycle(mcycle));
   cbc_card_model i_card (.i_mclk(i_mclk), .i_bus(bus), .o_data_in(din), .o_wr_addr(wr_addr),
      .o_wr_data(wr_data), .o_wr_count(wr_count));
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic issue(input logic [7:0] op, input logic [15:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge i_mclk);
      cmd <= '{1'b1, op, a, d};
      do begin
         @(posedge i_mclk);
         #1;
         n++;
      end while (taken !== 1'b1 && n < 200);
      `CHK(n < 200, 1'b1)
      @(posedge i_mclk);
      cmd.valid <= 1'b0;
   endtask
   task automatic wait_done;
      int n;
      n = 0;
      do begin
         @(posedge i_mclk);
         #1;
         n++;
      end while (done !== 1'b1 && n < 400);
      `CHK(n < 400, 1'b1)
   endtask
   task automatic t_input(input logic [7:0] dev, input logic [7:0] hi, input logic g);
      logic [15:0] pc0;
      pc0 = pc;
      exp_rd = g ? (dev ^ 8'h5A) : exp_rd;
      @(posedge i_mclk);
      gate <= g;
      issue(OP_INPUT, {hi, dev}, 8'h00);
      `CHK(mcycle, MCYC_INPUT)
      `CHK(pc, pc0)
      wait_done();
      `CHK(rdata, exp_rd)
      `CHK(pc, pc0 + PC_STEP)
      `CHK(bus.address_lines, {dev, dev})
      `CHK(bus.input_cycle_status, 1'b1)
      `CHK(panel.input_indicator, 1'b1)
      $display("test input %h done", dev);
   endtask
   task automatic t_store(input logic [15:0] a, input logic [7:0] d);
      logic [15:0] pc0;
      int          c0;
      pc0 = pc;
      c0 = wr_count;
      issue(OP_STORE, a, d);
      `CHK(mcycle, MCYC_MEMORY_WRITE_STROBE)
      wait_done();
      @(posedge i_mclk);
      #1;
      `CHK(wr_count, c0 + 1)
      `CHK(wr_addr, a)
      `CHK(wr_data, d)
      `CHK(pc, pc0)
      `CHK(bus.write_output_status_n, 1'b0)
      `CHK(panel.write_out_indicator, 1'b1)
      `CHK(bus.output_cycle_status, 1'b0)
      $display("test store %h done", a);
   endtask
   task automatic t_bad;
      logic bad;
      int   c0;
      bad = 1'b0;
      c0 = wr_count;
      issue(8'h00, 16'h1234, 8'h55);
      repeat (70) begin
         @(posedge i_mclk);
         #1;
         bad = bad | (bufc.chip_select_n !== 1'b1);
      end
      `CHK(bad, 1'b0)
      `CHK(wr_count, c0)
      $display("test unknown opcode done");
   endtask
   always @(posedge i_mclk) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         wrap_up();
      end
   end
   initial begin
      cmd = '0;
      gate = 1'b1;
      exp_rd = BYTE_RESET;
      repeat (11) @(posedge i_mclk);
      #1;
      `CHK(bus.memory_write_strobe, 1'b0)
      `CHK(bus.status_strobe_n, 1'b1)
      @(posedge i_mclk);
      i_rst_n <= 1'b1;
      t_input(8'h3C, 8'hFF, 1'b1);
      t_store(16'h0080, 8'hA7);
      t_input(8'hC5, 8'h00, 1'b0);
      t_input(8'hFF, 8'h12, 1'b1);
      t_store(16'hFFFF, 8'h00);
      t_bad();
      wrap_up();
   end
endmodule
`default_nettype wire
